//--- common/drive_trip_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the trip supervisor
// Assumes: 25 MHz system clock, one APB word per register
// Notes: Percent fields hold whole percent; wait time holds tenths of a second
`ifndef DRIVE_TRIP_DEFS_SVH
`define DRIVE_TRIP_DEFS_SVH
`define DTR_OFS_CTRL 8'h00
`define DTR_OFS_THERM 8'h04
`define DTR_OFS_RATED 8'h08
`define DTR_OFS_RETRY 8'h0C
`define DTR_OFS_STATUS 8'h10
`define DTR_OFS_CMD 8'h14
`define DTR_CTRL_THERM_EN 0
`define DTR_CTRL_SELF_COOL 1
`define DTR_CTRL_RST_RESTART 2
`define DTR_CMD_RESET_KEY 0
`define DTR_ONEMIN_RST 8'h96
`define DTR_ONEMIN_MAX 8'hC8
`define DTR_CONT_RST 8'h64
`define DTR_CONT_MIN 8'h32
`define DTR_CONT_MAX 8'h96
`define DTR_RATED_RST 16'h0064
`define DTR_LIMIT_MAX 4'hA
`define DTR_LIMIT_RST 4'h0
`define DTR_WAIT_MAX 10'h258
`define DTR_WAIT_RST 10'h00A
`define DTR_FS_FULL 8'h80
`define DTR_PCT 100
`define DTR_CLK_HZ 25000000
`define DTR_TICK_MS 1
`define DTR_TICK_CYC ((`DTR_CLK_HZ / 1000) * `DTR_TICK_MS)
`define DTR_DS_MS 100
`define DTR_DS_TICKS (`DTR_DS_MS / `DTR_TICK_MS)
`define DTR_RETRY_WIN_S 30
`define DTR_WIN_DS ((`DTR_RETRY_WIN_S * 1000) / `DTR_DS_MS)
`define DTR_HEAT_TRIP_S 60
`define DTR_HEAT_TICKS ((`DTR_HEAT_TRIP_S * 1000) / `DTR_TICK_MS)
`endif

//--- common/drive_trip_pkg.sv
// Purpose: Types shared by the trip supervisor
// Assumes: Nothing beyond the defs header
// Notes: State codes are visible in the status register
package drive_trip_pkg;
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_DECEL = 3'b001,
        ST_RUN = 3'b010,
        ST_FAULT = 3'b011,
        ST_WAIT = 3'b100
    } state_t;
endpackage

//--- verilog/drive_trip_restart_supervisor.sv
// Purpose: Thermal I2t trip, start qualification and counted auto restart for a motor drive
// Assumes: Current and frequency scale come from logic on clk; run and trip inputs are pins
// Notes: Heat grows per 1 ms tick; retry timing has 100 ms granularity
// Summary of operation
// - Enabled thermal protection at heat limit blocks gates and raises thermal fault.
// - One-minute level limited to continuous level..200 percent, resets to 150.
// - Continuous level limited to 50..one-minute level, at most 150, resets 100.
// - Both levels are percent of the programmed motor rated current.
// - Self-cooled motor: continuous threshold shrinks as output frequency falls.
// - Separately powered fan: continuous threshold used unchanged at any frequency.
// - Heat integrates current squared over time, never cleared on start or stop.
// - Power-up start enabled runs at once if run active, else needs fresh edge.
// - Start while motor still turns first decelerates to standstill, then runs.
// - Restart-after-reset enabled runs on fault clear, else needs fresh run edge.
// - Any trip removes gate drive at once; motor coasts.
// - Retry limit settable 0..10, resets to 0, zero disables auto restart.
// - Retryable trip clears itself, waits 0.0..60.0 s delay (reset 1.0 s), restarts.
// - Past the limit: no more restarts, gates blocked, fault held.
// - Successful restart keeps counter; failed restart adds one; no auto clearing.
// - Counter cleared by power cycle.
// - At the limit operator manual reset clears trip and zeroes the counter.
// - Listed severe trips, thermal included, never restart automatically.
// - Trip within 30 s of auto restart counts a failure, never beyond limit.
`timescale 1ns/1ps
`include "drive_trip_defs.svh"
module drive_trip_restart_supervisor #(
    parameter int unsigned TICK_CYCLES = `DTR_TICK_CYC
)(
    input wire logic clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic forwardRunInput,
    input wire logic reverseRunInput,
    input wire logic extTripIn,
    input wire logic extTripNoRetry,
    input wire logic [15:0] motorCurrent,
    input wire logic [7:0] freqScale,
    input wire logic motorStopped,
    input wire logic powerUpStartEnable,
    output logic gateEnable,
    output logic runCmd,
    output logic decelCmd,
    output logic faultOut,
    output logic thermalTripOut,
    output logic lockoutOut
);
    import drive_trip_pkg::*;

    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [2:0] ctrl_q;
    logic [7:0] oneMin_q;
    logic [7:0] cont_q;
    logic [15:0] rated_q;
    logic [3:0] retryLimit_q;
    logic [9:0] retryWait_q;
    logic [3:0] sync1_q, sync2_q, sync3_q, pinLvl_q;
    logic [31:0] tickCnt_q;
    logic msTick_q;
    logic [6:0] dsCnt_q;
    logic dsTick_q;
    logic [63:0] heat_q;
    logic thermalTrip_q;
    state_t state_q;
    logic armed_q, firstCycle_q;
    logic [3:0] settle_q;
    logic [3:0] attemptCnt_q;
    logic [9:0] waitCnt_q;
    logic [8:0] winCnt_q;
    logic lockout_q;
    logic gateEnable_q, runCmd_q, decelCmd_q, faultOut_q;

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign gateEnable = gateEnable_q;
    assign runCmd = runCmd_q;
    assign decelCmd = decelCmd_q;
    assign faultOut = faultOut_q;
    assign thermalTripOut = thermalTrip_q;
    assign lockoutOut = lockout_q;

    // Bus decode; the access phase always completes in its first cycle
    logic wrEn, known, rstKey;
    assign wrEn = psel && penable && pready_q && pwrite;
    assign known = (paddr == `DTR_OFS_CTRL) || (paddr == `DTR_OFS_THERM)
        || (paddr == `DTR_OFS_RATED) || (paddr == `DTR_OFS_RETRY)
        || (paddr == `DTR_OFS_STATUS) || (paddr == `DTR_OFS_CMD);
    assign rstKey = wrEn && (paddr == `DTR_OFS_CMD) && pwdata[`DTR_CMD_RESET_KEY];

    // Level clamps applied on the write, so illegal settings never reach the math
    logic [7:0] wrOne, wrCont, oneLim, contCap;
    always_comb
    begin
        wrOne = (pwdata[7:0] > `DTR_ONEMIN_MAX) ? `DTR_ONEMIN_MAX : pwdata[7:0];
        contCap = (wrOne < `DTR_CONT_MAX) ? wrOne : `DTR_CONT_MAX;
        wrCont = (pwdata[15:8] > contCap) ? contCap : pwdata[15:8];
        if (wrCont < `DTR_CONT_MIN)
        begin
            wrCont = `DTR_CONT_MIN;
        end
        oneLim = (wrOne < wrCont) ? wrCont : wrOne;
    end

    // Writable settings
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_q <= 3'h0;
            oneMin_q <= `DTR_ONEMIN_RST;
            cont_q <= `DTR_CONT_RST;
            rated_q <= `DTR_RATED_RST;
            retryLimit_q <= `DTR_LIMIT_RST;
            retryWait_q <= `DTR_WAIT_RST;
        end
        else if (clkEn && wrEn)
        begin
            case (paddr)
                `DTR_OFS_CTRL: ctrl_q <= pwdata[2:0];
                `DTR_OFS_THERM:
                begin
                    oneMin_q <= oneLim;
                    cont_q <= wrCont;
                end
                `DTR_OFS_RATED: rated_q <= pwdata[15:0];
                `DTR_OFS_RETRY:
                begin
                    retryLimit_q <= (pwdata[3:0] > `DTR_LIMIT_MAX) ?
                        `DTR_LIMIT_MAX : pwdata[3:0];
                    retryWait_q <= (pwdata[25:16] > `DTR_WAIT_MAX) ?
                        `DTR_WAIT_MAX : pwdata[25:16];
                end
                default: ;
            endcase
        end
    end

    // Read data and ready are prepared in the setup cycle
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else if (clkEn)
        begin
            pready_q <= psel && !penable;
            pslverr_q <= psel && !penable && !known;
            prdata_q <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    `DTR_OFS_CTRL: prdata_q <= {29'h0, ctrl_q};
                    `DTR_OFS_THERM: prdata_q <= {16'h0000, cont_q, oneMin_q};
                    `DTR_OFS_RATED: prdata_q <= {16'h0000, rated_q};
                    `DTR_OFS_RETRY: prdata_q <= {6'h00, retryWait_q, 12'h000, retryLimit_q};
                    `DTR_OFS_STATUS: prdata_q <= {heat_q[47:32], 1'b0, state_q,
                        attemptCnt_q, 2'h0, armed_q, thermalTrip_q, lockout_q,
                        runCmd_q, gateEnable_q, faultOut_q};
                    default: prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Pin synchronisers: a level counts once stages two and three agree
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 4'h0;
            pinLvl_q <= 4'h0;
            settle_q <= 4'h0;
        end
        else if (clkEn)
        begin
            sync1_q <= {extTripNoRetry, extTripIn, reverseRunInput, forwardRunInput};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pinLvl_q <= (~(sync2_q ^ sync3_q) & sync3_q) | ((sync2_q ^ sync3_q) & pinLvl_q);
            settle_q <= {settle_q[2:0], 1'b1};
        end
    end

    logic runAct;
    assign runAct = pinLvl_q[0] | pinLvl_q[1];

    // Levels read low until the chain fills; a held pin must not look released
    logic pinsValid;
    assign pinsValid = settle_q[3];

    // Millisecond and 100 ms time bases
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            tickCnt_q <= 32'h0000_0000;
            msTick_q <= 1'b0;
            dsCnt_q <= 7'h00;
            dsTick_q <= 1'b0;
        end
        else if (clkEn)
        begin
            msTick_q <= (tickCnt_q == TICK_CYCLES - 1);
            tickCnt_q <= (tickCnt_q == TICK_CYCLES - 1) ? 32'h0000_0000 : tickCnt_q + 1;
            dsTick_q <= 1'b0;
            if (msTick_q)
            begin
                dsTick_q <= (dsCnt_q == 7'(`DTR_DS_TICKS - 1));
                dsCnt_q <= (dsCnt_q == 7'(`DTR_DS_TICKS - 1)) ? 7'h00 : dsCnt_q + 7'h01;
            end
        end
    end

    // Thresholds in current units; self-cooling derates below base frequency
    logic [7:0] fsClip, contEff;
    logic [16:0] contProd;
    logic [23:0] curScaled, contThr, nomThr, oneThr;
    logic [47:0] curSq, contSq, nomSq, oneSq;
    logic [63:0] heatLimit;
    logic thermHit;
    always_comb
    begin
        fsClip = (freqScale > `DTR_FS_FULL) ? `DTR_FS_FULL : freqScale;
        contProd = 17'(cont_q) * (17'(`DTR_FS_FULL) + 17'(fsClip));
        contEff = ctrl_q[`DTR_CTRL_SELF_COOL] ? contProd[15:8] : cont_q;
        curScaled = 24'(motorCurrent) * 24'(`DTR_PCT);
        contThr = 24'(contEff) * 24'(rated_q);
        nomThr = 24'(cont_q) * 24'(rated_q);
        oneThr = 24'(oneMin_q) * 24'(rated_q);
        curSq = 48'(curScaled) * 48'(curScaled);
        contSq = 48'(contThr) * 48'(contThr);
        nomSq = 48'(nomThr) * 48'(nomThr);
        oneSq = 48'(oneThr) * 48'(oneThr);
        heatLimit = 64'(oneSq - nomSq) * 64'(`DTR_HEAT_TICKS);
        thermHit = ctrl_q[`DTR_CTRL_THERM_EN] && (heatLimit != 64'h0000_0000_0000_0000)
            && (heat_q >= heatLimit);
    end

    // Heat estimate: rises above threshold, cools below, kept across starts
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            heat_q <= 64'h0000_0000_0000_0000;
        end
        else if (clkEn && msTick_q)
        begin
            if (curSq > contSq)
            begin
                heat_q <= heat_q + 64'(curSq - contSq);
            end
            else if (heat_q > 64'(contSq - curSq))
            begin
                heat_q <= heat_q - 64'(contSq - curSq);
            end
            else
            begin
                heat_q <= 64'h0000_0000_0000_0000;
            end
        end
    end

    // Trip decision and retry bookkeeping
    logic extTrip, noRetry, tripEv, inWin, retryOk, manualClr, waitDone, startReq;
    logic [3:0] cntAfter;
    assign extTrip = pinLvl_q[2];
    assign noRetry = thermHit || pinLvl_q[3];
    assign tripEv = (thermHit || extTrip) && (state_q != ST_FAULT);
    assign inWin = (winCnt_q != 9'h000);
    assign cntAfter = (inWin && attemptCnt_q < retryLimit_q) ?
        attemptCnt_q + 4'h1 : attemptCnt_q;
    assign retryOk = !noRetry && (cntAfter < retryLimit_q);
    assign manualClr = (state_q == ST_FAULT) && rstKey;
    assign waitDone = (state_q == ST_WAIT) && (waitCnt_q == 10'h000) && !tripEv;
    assign startReq = (state_q == ST_IDLE) && armed_q && runAct && !tripEv;

    // Thermal trip flag: set wins over the reset key
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            thermalTrip_q <= 1'b0;
        end
        else if (clkEn)
        begin
            if (thermHit)
            begin
                thermalTrip_q <= 1'b1;
            end
            else if (manualClr)
            begin
                thermalTrip_q <= 1'b0;
            end
        end
    end

    // Start latch: armed when the run input is seen inactive, at power-up start, on reset-key restart or at retry wait end
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            armed_q <= 1'b0;
            firstCycle_q <= 1'b1;
        end
        else if (clkEn)
        begin
            firstCycle_q <= 1'b0;
            if (firstCycle_q)
            begin
                armed_q <= powerUpStartEnable;
            end
            else if (!runAct && pinsValid)
            begin
                armed_q <= 1'b1;
            end
            else if (manualClr)
            begin
                armed_q <= ctrl_q[`DTR_CTRL_RST_RESTART];
            end
            else if (waitDone)
            begin
                armed_q <= 1'b1;
            end
        end
    end

    // Attempt counter; only a power cycle or the reset key zeroes it
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            attemptCnt_q <= 4'h0;
        end
        else if (clkEn)
        begin
            if (tripEv)
            begin
                attemptCnt_q <= cntAfter;
            end
            else if (manualClr)
            begin
                attemptCnt_q <= 4'h0;
            end
        end
    end

    // Retry delay and the 30 s watch window after an automatic restart
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            waitCnt_q <= 10'h000;
            winCnt_q <= 9'h000;
        end
        else if (clkEn)
        begin
            if (tripEv)
            begin
                waitCnt_q <= retryWait_q;
                winCnt_q <= 9'h000;
            end
            else
            begin
                if (dsTick_q && waitCnt_q != 10'h000)
                begin
                    waitCnt_q <= waitCnt_q - 10'h001;
                end
                if (waitDone)
                begin
                    winCnt_q <= 9'(`DTR_WIN_DS);
                end
                else if (dsTick_q && inWin)
                begin
                    winCnt_q <= winCnt_q - 9'h001;
                end
            end
        end
    end

    // Run sequence; a trip in any state other than ST_FAULT wins
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_q <= ST_IDLE;
            lockout_q <= 1'b0;
        end
        else if (clkEn)
        begin
            if (tripEv)
            begin
                state_q <= retryOk ? ST_WAIT : ST_FAULT;
                lockout_q <= !retryOk;
            end
            else
            begin
                case (state_q)
                    ST_IDLE:
                    begin
                        if (startReq)
                        begin
                            state_q <= motorStopped ? ST_RUN : ST_DECEL;
                        end
                    end
                    ST_DECEL:
                    begin
                        if (!runAct)
                        begin
                            state_q <= ST_IDLE;
                        end
                        else if (motorStopped)
                        begin
                            state_q <= ST_RUN;
                        end
                    end
                    ST_RUN:
                    begin
                        if (!runAct)
                        begin
                            state_q <= ST_IDLE;
                        end
                    end
                    ST_FAULT:
                    begin
                        if (manualClr)
                        begin
                            state_q <= ST_IDLE;
                            lockout_q <= 1'b0;
                        end
                    end
                    ST_WAIT:
                    begin
                        if (waitDone)
                        begin
                            state_q <= ST_IDLE;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // Output stage; gates drop in the same edge that records a trip
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            gateEnable_q <= 1'b0;
            runCmd_q <= 1'b0;
            decelCmd_q <= 1'b0;
            faultOut_q <= 1'b0;
        end
        else if (clkEn)
        begin
            gateEnable_q <= !tripEv && (state_q == ST_RUN || state_q == ST_DECEL
                || startReq);
            runCmd_q <= !tripEv && ((state_q == ST_RUN && runAct)
                || (state_q == ST_DECEL && runAct && motorStopped)
                || (startReq && motorStopped));
            decelCmd_q <= !tripEv && ((state_q == ST_DECEL && runAct && !motorStopped)
                || (startReq && !motorStopped));
            faultOut_q <= (tripEv && !retryOk) || (state_q == ST_FAULT && !manualClr);
        end
    end

    property p_tripGates;
        @(posedge clk) disable iff (srst) (clkEn && tripEv) |=> !gateEnable_q && !runCmd_q;
    endproperty
    a_tripGates: assert property (p_tripGates) else $error("gates live after trip");

    property p_thermBlock;
        @(posedge clk) disable iff (srst) thermalTrip_q |-> !gateEnable_q && lockout_q;
    endproperty
    a_thermBlock: assert property (p_thermBlock) else $error("thermal trip not blocking");

    property p_oneRange;
        @(posedge clk) disable iff (srst) oneMin_q <= 8'hC8 && oneMin_q >= cont_q;
    endproperty
    a_oneRange: assert property (p_oneRange) else $error("one minute level out of range");

    property p_contRange;
        @(posedge clk) disable iff (srst) cont_q >= 8'h32 && cont_q <= 8'h96;
    endproperty
    a_contRange: assert property (p_contRange) else $error("continuous level out of range");

    property p_cntLimit;
        @(posedge clk) disable iff (srst) (clkEn && tripEv && inWin && retryLimit_q != 4'h0)
            |=> attemptCnt_q <= retryLimit_q && attemptCnt_q <= 4'hA;
    endproperty
    a_cntLimit: assert property (p_cntLimit) else $error("attempt count beyond limit");

    property p_lockHold;
        @(posedge clk) disable iff (srst) (clkEn && state_q == ST_FAULT && !rstKey)
            |=> state_q == ST_FAULT && faultOut_q && !gateEnable_q;
    endproperty
    a_lockHold: assert property (p_lockHold) else $error("fault left without reset key");

    property p_keyClears;
        @(posedge clk) disable iff (srst) (clkEn && manualClr)
            |=> attemptCnt_q == 4'h0 && state_q == ST_IDLE;
    endproperty
    a_keyClears: assert property (p_keyClears) else $error("reset key did not clear");

    property p_spinStart;
        @(posedge clk) disable iff (srst) (clkEn && startReq && !motorStopped)
            |=> decelCmd_q && !runCmd_q && state_q == ST_DECEL;
    endproperty
    a_spinStart: assert property (p_spinStart) else $error("run without decel on spin");

    property p_powerUp;
        @(posedge clk) disable iff (srst) (clkEn && firstCycle_q && !powerUpStartEnable)
            |=> !armed_q;
    endproperty
    a_powerUp: assert property (p_powerUp) else $error("armed at power up");

    property p_waitRestart;
        @(posedge clk) disable iff (srst) (clkEn && waitDone)
            |=> state_q == ST_IDLE && armed_q && winCnt_q == 9'h12C;
    endproperty
    a_waitRestart: assert property (p_waitRestart) else $error("auto restart not taken");
endmodule

//--- verification/drive_motor_model.sv
// Purpose: Motor shaft seen from the gate drive; speeds up under drive, coasts down without it
// Assumes: Outputs of the supervisor are registered on clk
// Notes: Speed is a coarse count, so a stop follows well under 300 cycles of coasting
`timescale 1ns/1ps
module drive_motor_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic gateEnable,
    input wire logic runCmd,
    output logic motorStopped
);
    logic [7:0] speedQ;

    // Shaft speed; without gate drive it only ever winds down
    always_ff @(posedge clk)
    begin
        if (srst)
            speedQ <= 8'h00;
        else if (gateEnable && runCmd && speedQ != 8'hFF)
            speedQ <= speedQ + 8'h01;
        else if (speedQ != 8'h00)
            speedQ <= speedQ - 8'h01; // Coast or braked stop
    end

    // Standstill only at zero, so a quick restart still sees rotation
    assign motorStopped = (speedQ == 8'h00);
endmodule

//--- verification/tb_drive_trip_restart_supervisor.sv
// Purpose: Self-checking bench for start, trip, retry, lockout and thermal behaviour
// Assumes: One millisecond tick shortened to 10 cycles
// Notes: Retry delay set to 0.1 s so waits stay near a thousand cycles
`timescale 1ns/1ps
`include "drive_trip_defs.svh"
module tb_drive_trip_restart_supervisor;
    logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic pready, pslverr, e, gateEnable, runCmd, decelCmd, faultOut, thermalTripOut, lockoutOut;
    logic fwd = 1, tripIn = 0, noRetry = 0, pue = 0, motorStopped;
    logic [7:0] freq = 8'h80;
    logic [15:0] current = 16'h0000;
    int errors = 0, n_compared = 0;
    wire logic [4:0] outs = {thermalTripOut, faultOut, decelCmd, runCmd, gateEnable};

    always #20 clk = ~clk;

    drive_trip_restart_supervisor #(.TICK_CYCLES(10)) u_dut (.clk(clk), .srst(srst),
        .clkEn(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .forwardRunInput(fwd), .reverseRunInput(1'b0), .extTripIn(tripIn),
        .extTripNoRetry(noRetry), .motorCurrent(current), .freqScale(freq),
        .motorStopped(motorStopped), .powerUpStartEnable(pue), .gateEnable(gateEnable),
        .runCmd(runCmd), .decelCmd(decelCmd), .faultOut(faultOut),
        .thermalTripOut(thermalTripOut), .lockoutOut(lockoutOut));
    drive_motor_model u_motor (.clk(clk), .srst(srst), .gateEnable(gateEnable),
        .runCmd(runCmd), .motorStopped(motorStopped));

    // One APB transfer; request held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
        // Idle edge, so a following call never re-raises psel in this time step
        @(posedge clk);
    endtask

    task chk(input string s, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x)
        begin
            $display("BAD %s expected %h seen %h", s, x, g);
            errors++;
        end
    endtask

    // Bounded wait for one supervisor output to reach a level
    task wt(input int k, input logic v);
        int n;
        n = 0;
        while (outs[k] !== v && n < 5000)
        begin
            @(posedge clk);
            n++;
        end
        chk($sformatf("output %0d", k), {31'h0, v}, {31'h0, outs[k]});
    endtask

    task t_regs;
        apb(0, `DTR_OFS_THERM, 0); chk("therm reset", 32'h0000_6496, r);
        apb(0, `DTR_OFS_RETRY, 0); chk("retry reset", 32'h000A_0000, r);
        apb(1, `DTR_OFS_THERM, 32'h0000_10FF);
        apb(0, `DTR_OFS_THERM, 0); chk("therm clamp", 32'h0000_32C8, r);
        apb(1, `DTR_OFS_RETRY, 32'h03FF_000F);
        apb(0, `DTR_OFS_RETRY, 0); chk("retry clamp", 32'h0258_000A, r);
        apb(0, 8'h40, 0); chk("unmapped", 32'h1, {31'h0, e});
        apb(1, `DTR_OFS_RETRY, 32'h0001_0002);
    endtask

    // Run pin held since power-up must not start; a fresh edge must
    task t_start;
        repeat (20) @(posedge clk);
        chk("no power-up start", 32'h0, {31'h0, gateEnable});
        fwd <= 0;
        repeat (8) @(posedge clk);
        fwd <= 1;
        wt(0, 1);
        chk("run", 32'h1, {31'h0, runCmd});
    endtask

    // Retryable trips: coast, self clear, restart; second one counts
    task t_retry;
        repeat (2)
        begin
            tripIn <= 1;
            repeat (6) @(posedge clk);
            tripIn <= 0;
            chk("gate off", 32'h0, {31'h0, gateEnable});
            chk("fault self clear", 32'h0, {31'h0, faultOut});
            wt(0, 1);
        end
        apb(0, `DTR_OFS_STATUS, 0); chk("attempts", 32'h1, {28'h0, r[11:8]});
    endtask

    // Severe trip locks out; reset key with restart enabled brakes then runs
    task t_fault;
        repeat (100) @(posedge clk);
        apb(1, `DTR_OFS_CTRL, 32'h0000_0004);
        noRetry <= 1; tripIn <= 1;
        wt(3, 1);
        chk("lockout", 32'h1, {31'h0, lockoutOut});
        chk("gate blocked", 32'h0, {31'h0, gateEnable});
        noRetry <= 0; tripIn <= 0;
        repeat (6) @(posedge clk);
        apb(1, `DTR_OFS_CMD, 32'h0000_0001);
        wt(2, 1);
        wt(1, 1);
        apb(0, `DTR_OFS_STATUS, 0); chk("attempts zero", 32'h0, {28'h0, r[11:8]});
    endtask

    task t_therm;
        apb(1, `DTR_OFS_CTRL, 32'h0000_0005);
        apb(1, `DTR_OFS_THERM, 32'h0000_3233);
        current <= 16'hFFFF;
        wt(4, 1);
        chk("thermal gate", 32'h0, {31'h0, gateEnable});
        chk("thermal fault", 32'h1, {31'h0, faultOut});
    endtask

    // Current at the continuous level: no heat with a fan, heat when self-cooled at standstill
    task t_cool;
        apb(1, `DTR_OFS_THERM, 32'h0000_9697);
        current <= 16'h0096;
        freq <= 8'h00;
        repeat (400) @(posedge clk);
        apb(0, `DTR_OFS_STATUS, 0); chk("fan cooled heat", 32'h0, {31'h0, |r[31:16]});
        apb(1, `DTR_OFS_CTRL, 32'h0000_0006);
        repeat (400) @(posedge clk);
        apb(0, `DTR_OFS_STATUS, 0); chk("self cooled heat", 32'h1, {31'h0, |r[31:16]});
    endtask

    // Second reset with power-up start on: the held run pin starts at once
    task t_powerup;
        pue <= 1;
        srst <= 1;
        repeat (3) @(posedge clk);
        srst <= 0;
        wt(0, 1);
        chk("power-up run", 32'h1, {31'h0, runCmd});
    endtask

    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Main sequence after a three-cycle reset
    initial
    begin
        repeat (3) @(posedge clk);
        srst <= 0;
        @(posedge clk);
        t_regs;
        t_start;
        t_retry;
        t_fault;
        t_cool;
        t_therm;
        t_powerup;
        report_and_stop;
    end

    // Watchdog well beyond the few thousand cycles the sequence needs
    initial
    begin
        repeat (40000) @(posedge clk);
        errors++;
        report_and_stop;
    end
endmodule
